// ==== core/pwr_map.svh ====
// Register offsets, field positions, reset values and timing constants
// Operation
// - Bit 2 powers spindle converter, resets set
// - Bit 1 powers reference and clocks rest
// - Clearing auto bit parks servo modules, ladder
// - Setting auto bit during park restores modules
// - Search wakes converter, sequencers; power-on wakes ladder
// - Core stops on stop; restarts within 12
// - Terminal clock wakes on write, rx, tx
// - Sequencers wake on write, reset, search
// - Ladder wakes on write, reset, power-on set
// - Oscillator halted by core, restarts on interrupt
// - Trim bits 8, 7 enable ladder buffers
// - Trim bit 6 selects reference level
// - Trim bits 5:3 hold bandgap adjust code
// - Trim bits 2:0 hold reference gain code
// - Trim bits 15:9 read zero, ignore writes
// - Ladder hold keeps ladder on, else follows
`ifndef PWR_MAP_SVH
`define PWR_MAP_SVH

`define DEC_W 8
`define REG_W 16
`define OFF_POWER_CONTROL 8'h00
`define OFF_REFERENCE_TRIM 8'h04
`define OFF_POWER_STATUS 8'h08
`define HTRANS_ACTIVE_BIT 1
`define HRESP_OKAY 1'b0

`define PC_RESET 16'hffff
`define PC_WR_MASK 16'h1fff
`define PC_AUTO 0
`define PC_REST 1
`define PC_SPINDLE 2
`define PC_LADDER_HOLD 5
`define PC_CONVERTER 6
`define PC_SEQUENCER 7
`define PC_TERMINAL 8
`define PC_OSC_PD 9

`define RT_RESET 16'h01a4
`define RT_WR_MASK 16'h01ff
`define RT_RSVD_MSB 15
`define RT_RSVD_LSB 9
`define RT_CENTRE 8
`define RT_BOTTOM 7
`define RT_LEVEL 6
`define RT_BG_LSB 3
`define RT_GAIN_LSB 0
`define TRIM_W 3

`define ST_DSP_RUN 0
`define ST_OSC_RUN 1
`define ST_SERVO_DOWN 2
`define ST_LADDER_DOWN 3
`define ST_LADDER_READY 4
`define ST_TERM_ACTIVE 5

`define CLK_PERIOD_NS 4
`define DSP_RESUME_CLKS 12
`define DSP_CNT_W 4
`define WAKE_CLKS 2
`define LADDER_SETTLE_NS 20000
`define LADDER_CNT_W 13

`endif

// ==== core/pwr_pkg.sv ====
// Types shared by the power gating block
`default_nettype none
`include "pwr_map.svh"
package pwr_pkg;
    typedef logic [`REG_W-1:0] reg_word_t;
    typedef enum logic {SERVO_RUN, SERVO_DOWN} servo_state_t;
endpackage : pwr_pkg
`default_nettype wire

// ==== core/pin_sync.sv ====
// Two-stage synchroniser for pin inputs
`default_nettype none
module pin_sync
    import pwr_pkg::*;
#(
    parameter int unsigned WIDTH = 1
)
(
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [WIDTH-1:0] pin_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta;

    // First stage feeds only the second stage
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            meta <= '0;
            sync_o <= '0;
        end
        else
        begin
            meta <= pin_i;
            sync_o <= meta;
        end
    end
endmodule : pin_sync
`default_nettype wire

// ==== core/wake_timer.sv ====
// Recovery counter: settled level after a wake start
`default_nettype none
module wake_timer
    import pwr_pkg::*;
#(
    parameter int unsigned WIDTH = 4,
    parameter logic [WIDTH-1:0] CYCLES = WIDTH'(2),
    parameter logic RESET_SETTLED = 1'b1
)
(
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic start_i,
    input wire logic stop_i,
    output logic settled_o
);
    logic [WIDTH-1:0] cnt;
    logic [WIDTH-1:0] next_cnt;
    logic next_settled;

    // A start while running or counting is ignored so it never drops run
    always_comb
    begin
        next_cnt = cnt;
        next_settled = settled_o;
        if (start_i && !settled_o && cnt == '0)
        begin
            next_cnt = CYCLES - WIDTH'(1);
        end
        else if (stop_i && !start_i)
        begin
            next_cnt = '0;
            next_settled = 1'b0;
        end
        else if (cnt != '0)
        begin
            next_cnt = cnt - WIDTH'(1);
            if (cnt == WIDTH'(1))
            begin
                next_settled = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt <= '0;
            settled_o <= RESET_SETTLED;
        end
        else
        begin
            cnt <= next_cnt;
            settled_o <= next_settled;
        end
    end
endmodule : wake_timer
`default_nettype wire

// ==== core/power_gating_and_ref_trim.sv ====
// Power and clock gating with reference trim, AHB-Lite register slave
`default_nettype none
`include "pwr_map.svh"
module power_gating_and_ref_trim
    import pwr_pkg::*;
#(
    parameter logic [`LADDER_CNT_W-1:0] LADDER_SETTLE_CYCLES =
        `LADDER_CNT_W'((`LADDER_SETTLE_NS + `CLK_PERIOD_NS - 1)
        / `CLK_PERIOD_NS)
)
(
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    input wire logic servo_search_i,
    input wire logic power_on_set_i,
    input wire logic serial_rx_i,
    input wire logic dsp_stop_i,
    input wire logic unmasked_irq_i,
    input wire logic any_irq_i,
    input wire logic tx_write_i,
    input wire logic term_idle_i,
    output logic spindle_pwr_o,
    output logic ref_rest_pwr_o,
    output logic ref_rest_clk_o,
    output logic converter_pwr_o,
    output logic ladder_pwr_o,
    output logic ladder_ready_o,
    output logic seq_clk_o,
    output logic acq_clk_o,
    output logic term_clk_o,
    output logic dsp_run_o,
    output logic osc_run_o,
    output logic centre_buf_en_o,
    output logic bottom_buf_en_o,
    output logic reference_level_select_o,
    output logic [`TRIM_W-1:0] bandgap_adjust_o,
    output logic [`TRIM_W-1:0] reference_gain_o
);
    function automatic logic hit(input logic [`DEC_W-1:0] addr,
                                 input logic [`DEC_W-1:0] off);
        return addr == off;
    endfunction : hit

    logic ap_valid;
    logic ap_write;
    logic [`DEC_W-1:0] ap_addr;
    logic next_ap_valid;
    logic next_ap_write;
    logic [`DEC_W-1:0] next_ap_addr;
    logic [31:0] next_hrdata;
    logic taken;
    logic wr_pc;
    logic wr_rt;
    reg_word_t power_control;
    reg_word_t reference_trim;
    reg_word_t status_word;
    reg_word_t next_power_control;
    reg_word_t next_reference_trim;
    servo_state_t servo_state;
    servo_state_t next_servo_state;
    logic ladder_down;
    logic next_ladder_down;
    logic term_active;
    logic next_term_active;
    logic next_osc_run;
    logic [2:0] pin_s;
    logic [2:0] pin_prev;
    logic servo_search_rise;
    logic pon_rise;
    logic rx_edge;
    logic ladder_seen;
    logic servo_up;
    logic next_spindle;
    logic next_rest;
    logic next_converter;
    logic next_ladder;
    logic next_seq;
    logic next_acq;
    logic next_term_clk;

    // Register bus: zero wait states, read data fetched in the address phase
    always_comb
    begin
        taken = hsel_i && htrans_i[`HTRANS_ACTIVE_BIT] && hready_i;
        next_ap_valid = taken;
        next_ap_write = taken ? hwrite_i : ap_write;
        next_ap_addr = taken ? haddr_i[`DEC_W-1:0] : ap_addr;
        next_hrdata = hrdata_o;
        if (taken && !hwrite_i)
        begin
            next_hrdata = '0;
            if (hit(haddr_i[`DEC_W-1:0], `OFF_POWER_CONTROL))
                next_hrdata[`REG_W-1:0] = power_control;
            else if (hit(haddr_i[`DEC_W-1:0], `OFF_REFERENCE_TRIM))
                next_hrdata[`REG_W-1:0] = reference_trim;
            else if (hit(haddr_i[`DEC_W-1:0], `OFF_POWER_STATUS))
                next_hrdata[`REG_W-1:0] = status_word;
        end
        wr_pc = ap_valid && ap_write && hit(ap_addr, `OFF_POWER_CONTROL);
        wr_rt = ap_valid && ap_write && hit(ap_addr, `OFF_REFERENCE_TRIM);
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ap_valid <= 1'b0;
            ap_write <= 1'b0;
            ap_addr <= '0;
            hrdata_o <= '0;
            hreadyout_o <= 1'b1;
            hresp_o <= `HRESP_OKAY;
        end
        else
        begin
            ap_valid <= next_ap_valid;
            ap_write <= next_ap_write;
            ap_addr <= next_ap_addr;
            hrdata_o <= next_hrdata;
            hreadyout_o <= 1'b1;
            hresp_o <= `HRESP_OKAY;
        end
    end

    pin_sync #(.WIDTH(3)) u_pin_sync (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        // Receive line idles high: invert it so the reset value of the
        // synchroniser matches idle and no false edge follows reset
        .pin_i({~serial_rx_i, power_on_set_i, servo_search_i}),
        .sync_o(pin_s)
    );

    // Registers and wake state
    always_comb
    begin
        servo_search_rise = pin_s[0] && !pin_prev[0];
        pon_rise = pin_s[1] && !pin_prev[1];
        rx_edge = pin_s[2] ^ pin_prev[2];
        next_power_control = power_control;
        next_reference_trim = reference_trim;
        next_servo_state = servo_state;
        next_ladder_down = ladder_down;
        if (wr_pc)
            next_power_control = (power_control & ~`PC_WR_MASK)
                | (hwdata_i[`REG_W-1:0] & `PC_WR_MASK);
        if (wr_rt)
            next_reference_trim = hwdata_i[`REG_W-1:0]
                & `RT_WR_MASK;
        if (wr_pc && !hwdata_i[`PC_AUTO] && power_control[`PC_AUTO])
        begin
            next_servo_state = SERVO_DOWN;
            next_ladder_down = !hwdata_i[`PC_LADDER_HOLD];
        end
        else if (wr_pc && hwdata_i[`PC_AUTO])
        begin
            next_servo_state = SERVO_RUN;
            next_ladder_down = 1'b0;
        end
        // A wake in the cycle of the parking write still wins
        if (servo_search_rise && !next_power_control[`PC_AUTO])
            next_servo_state = SERVO_RUN;
        if (pon_rise && !next_power_control[`PC_AUTO])
            next_ladder_down = 1'b0;
        next_term_active = term_active;
        if (term_idle_i)
            next_term_active = 1'b0;
        if (rx_edge || tx_write_i)
            next_term_active = 1'b1;
        next_osc_run = osc_run_o;
        if (dsp_stop_i && !power_control[`PC_OSC_PD])
            next_osc_run = 1'b0;
        if (any_irq_i)
            next_osc_run = 1'b1;
        status_word = '0;
        status_word[`ST_DSP_RUN] = dsp_run_o;
        status_word[`ST_OSC_RUN] = osc_run_o;
        status_word[`ST_SERVO_DOWN] = servo_state == SERVO_DOWN;
        status_word[`ST_LADDER_DOWN] = ladder_down;
        status_word[`ST_LADDER_READY] = ladder_ready_o;
        status_word[`ST_TERM_ACTIVE] = term_active;
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            power_control <= `PC_RESET;
            reference_trim <= `RT_RESET;
            servo_state <= SERVO_RUN;
            ladder_down <= 1'b0;
            term_active <= 1'b0;
            osc_run_o <= 1'b1;
            pin_prev <= '0;
        end
        else
        begin
            power_control <= next_power_control;
            reference_trim <= next_reference_trim;
            servo_state <= next_servo_state;
            ladder_down <= next_ladder_down;
            term_active <= next_term_active;
            osc_run_o <= next_osc_run;
            pin_prev <= pin_s;
        end
    end

    // Gating enables
    always_comb
    begin
        servo_up = servo_state == SERVO_RUN;
        next_spindle = power_control[`PC_SPINDLE];
        next_rest = power_control[`PC_REST];
        next_converter = power_control[`PC_CONVERTER] && servo_up;
        next_seq = power_control[`PC_SEQUENCER] && servo_up;
        next_acq = servo_up;
        next_ladder = power_control[`PC_LADDER_HOLD]
            || (power_control[`PC_CONVERTER] && !ladder_down);
        next_term_clk = power_control[`PC_TERMINAL] || term_active
            || rx_edge || tx_write_i;
    end

    // Enables only change on a clock edge so gating never glitches
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            spindle_pwr_o <= 1'b1;
            ref_rest_pwr_o <= 1'b1;
            ref_rest_clk_o <= 1'b1;
            converter_pwr_o <= 1'b1;
            ladder_pwr_o <= 1'b1;
            seq_clk_o <= 1'b1;
            acq_clk_o <= 1'b1;
            term_clk_o <= 1'b1;
            ladder_seen <= 1'b0;
        end
        else
        begin
            spindle_pwr_o <= next_spindle;
            ref_rest_pwr_o <= next_rest;
            ref_rest_clk_o <= next_rest;
            converter_pwr_o <= next_converter;
            ladder_pwr_o <= next_ladder;
            seq_clk_o <= next_seq;
            acq_clk_o <= next_acq;
            term_clk_o <= next_term_clk;
            ladder_seen <= ladder_pwr_o;
        end
    end

    always_comb
    begin
        centre_buf_en_o = reference_trim[`RT_CENTRE];
        bottom_buf_en_o = reference_trim[`RT_BOTTOM];
        reference_level_select_o = reference_trim[`RT_LEVEL];
        bandgap_adjust_o = reference_trim[`RT_BG_LSB +: `TRIM_W];
        reference_gain_o = reference_trim[`RT_GAIN_LSB +: `TRIM_W];
    end

    // Core restart: any unmasked interrupt or a servo search
    wake_timer #(
        .WIDTH(`DSP_CNT_W),
        .CYCLES(`DSP_CNT_W'(`DSP_RESUME_CLKS)),
        .RESET_SETTLED(1'b1)
    ) u_dsp_wake (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .start_i(servo_search_rise || unmasked_irq_i),
        .stop_i(dsp_stop_i),
        .settled_o(dsp_run_o)
    );

    // Ladder settle: ready only after the full recovery time
    wake_timer #(
        .WIDTH(`LADDER_CNT_W),
        .CYCLES(LADDER_SETTLE_CYCLES),
        .RESET_SETTLED(1'b0)
    ) u_ladder_wake (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .start_i(ladder_pwr_o && !ladder_seen),
        .stop_i(!ladder_pwr_o),
        .settled_o(ladder_ready_o)
    );

    property p_spindle;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        wr_pc |-> ##2 spindle_pwr_o == $past(hwdata_i[`PC_SPINDLE], 2);
    endproperty
    a_spindle: assert property (p_spindle)
        else $error("spindle power does not follow its bit");

    property p_rest;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        wr_pc |-> ##2 (ref_rest_pwr_o == $past(hwdata_i[`PC_REST], 2))
            && (ref_rest_clk_o == ref_rest_pwr_o);
    endproperty
    a_rest: assert property (p_rest)
        else $error("reference power or clocks wrong");

    property p_park;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        ($fell(power_control[`PC_AUTO]) && !$past(servo_search_rise))
            |=> !converter_pwr_o && !seq_clk_o && !acq_clk_o;
    endproperty
    a_park: assert property (p_park)
        else $error("servo modules not parked");

    property p_unpark;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        $rose(power_control[`PC_AUTO]) |=> acq_clk_o
            && (converter_pwr_o == $past(power_control[`PC_CONVERTER]));
    endproperty
    a_unpark: assert property (p_unpark)
        else $error("setting auto did not restore modules");

    property p_search_wake;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (servo_search_rise && !power_control[`PC_AUTO] && !wr_pc
            && power_control[`PC_CONVERTER] && power_control[`PC_SEQUENCER])
            |-> ##[1:`WAKE_CLKS] (converter_pwr_o && seq_clk_o);
    endproperty
    a_search_wake: assert property (p_search_wake)
        else $error("search did not wake converter and sequencers");

    property p_dsp_resume;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (servo_search_rise || unmasked_irq_i) |-> ##[1:12] (dsp_run_o || dsp_stop_i);
    endproperty
    a_dsp_resume: assert property (p_dsp_resume)
        else $error("core did not resume in time");

    property p_term_wake;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (tx_write_i || rx_edge) |-> ##[1:`WAKE_CLKS] term_clk_o;
    endproperty
    a_term_wake: assert property (p_term_wake)
        else $error("terminal clock did not wake");

    property p_ladder_wake;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (pon_rise && !power_control[`PC_AUTO] && !wr_pc
            && power_control[`PC_CONVERTER]) |-> ##2 ladder_pwr_o;
    endproperty
    a_ladder_wake: assert property (p_ladder_wake)
        else $error("power-on set did not wake ladder");

    property p_osc;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        $fell(osc_run_o) |-> $past(dsp_stop_i)
            && !$past(power_control[`PC_OSC_PD]) && !$past(any_irq_i);
    endproperty
    a_osc: assert property (p_osc)
        else $error("oscillator halted without core action");

    property p_rsvd;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (taken && !hwrite_i
            && hit(haddr_i[`DEC_W-1:0], `OFF_REFERENCE_TRIM))
            |=> hrdata_o[`RT_RSVD_MSB:`RT_RSVD_LSB] == '0;
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("reserved trim bits not zero");

    property p_hold;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (power_control[`PC_LADDER_HOLD] && !wr_pc) |-> ##2 ladder_pwr_o;
    endproperty
    a_hold: assert property (p_hold)
        else $error("held ladder was powered down");
endmodule : power_gating_and_ref_trim
`default_nettype wire

// ==== sim/dsp_model.sv ====
// Core-side model: AHB-Lite master and wake, stop and interrupt sources
`default_nettype none
module dsp_model (
    input wire logic clk_sys_i,
    input wire logic [31:0] hrdata_i,
    input wire logic hready_i,
    output logic hsel_o,
    output logic [31:0] haddr_o,
    output logic [1:0] htrans_o,
    output logic hwrite_o,
    output logic [2:0] hsize_o,
    output logic [31:0] hwdata_o,
    output logic [7:0] side_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        hsel_o = 1'b0;
        haddr_o = 32'h0000_0000;
        htrans_o = 2'b00;
        hwrite_o = 1'b0;
        hsize_o = 3'b010;
        hwdata_o = 32'h0000_0000;
        side_o = 8'h04;
    end

    // Released address and data lines show the inverse, never a stale copy
    task automatic xfer(input logic wr, input logic [31:0] a,
                        input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk_sys_i);
        hsel_o <= 1'b1;
        haddr_o <= a;
        htrans_o <= 2'b10;
        hwrite_o <= wr;
        do @(posedge clk_sys_i); while (hready_i !== 1'b1);
        hsel_o <= 1'b0;
        htrans_o <= 2'b00;
        haddr_o <= ~a;
        hwdata_o <= wr ? wd : ~hwdata_o;
        do @(posedge clk_sys_i); while (hready_i !== 1'b1);
        rd = hrdata_i;
        hwdata_o <= ~wd;
    endtask : xfer

    // Receive line (index 2) idles high and only toggles
    task automatic pulse(input int k, input int w);
        @(posedge clk_sys_i);
        side_o[k] <= ~side_o[k];
        repeat (w) @(posedge clk_sys_i);
        if (k != 2)
            side_o[k] <= 1'b0;
    endtask : pulse
endmodule : dsp_model
`default_nettype wire

// ==== sim/power_gating_and_ref_trim_test.sv ====
// Self-checking bench for the power gating and reference trim block
`default_nettype none
`include "pwr_map.svh"
`define CHK(g, e) \
    begin \
        n_checks++; \
        if ((g) !== (e)) \
        begin \
            failures++; \
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); \
        end \
    end
module power_gating_and_ref_trim_test;
    timeunit 1ns;
    timeprecision 1ps;
    int failures = 0;
    int n_checks = 0;
    logic clk_sys_i, rst_n_i, hsel, hwrite, hready, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [7:0] side;
    logic spindle, rest_pwr, rest_clk, conv, ladder, ladder_rdy, seq, acq;
    logic term, dsp_run, osc_run, centre, bottom, level;
    logic [2:0] bg, gain;

    power_gating_and_ref_trim #(.LADDER_SETTLE_CYCLES(13'd20)) dut (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready),
        .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
        .servo_search_i(side[0]), .power_on_set_i(side[1]),
        .serial_rx_i(side[2]), .dsp_stop_i(side[3]),
        .unmasked_irq_i(side[4]), .any_irq_i(side[5]),
        .tx_write_i(side[6]), .term_idle_i(side[7]),
        .spindle_pwr_o(spindle), .ref_rest_pwr_o(rest_pwr),
        .ref_rest_clk_o(rest_clk), .converter_pwr_o(conv),
        .ladder_pwr_o(ladder), .ladder_ready_o(ladder_rdy),
        .seq_clk_o(seq), .acq_clk_o(acq), .term_clk_o(term),
        .dsp_run_o(dsp_run), .osc_run_o(osc_run),
        .centre_buf_en_o(centre), .bottom_buf_en_o(bottom),
        .reference_level_select_o(level), .bandgap_adjust_o(bg),
        .reference_gain_o(gain));

    dsp_model u_dsp (
        .clk_sys_i(clk_sys_i), .hrdata_i(hrdata), .hready_i(hready),
        .hsel_o(hsel), .haddr_o(haddr), .htrans_o(htrans),
        .hwrite_o(hwrite), .hsize_o(hsize), .hwdata_o(hwdata),
        .side_o(side));

    initial
    begin
        clk_sys_i = 1'b0;
        forever #2 clk_sys_i = ~clk_sys_i;
    end

    task automatic final_report;
        $display("checks=%0d failures=%0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : final_report

    // Gated outputs change two edges after the data phase
    task automatic wr(input logic [7:0] off, input logic [15:0] d);
        logic [31:0] unused;
        u_dsp.xfer(1'b1, {24'h00_0000, off}, {16'h0000, d}, unused);
        repeat (2) @(posedge clk_sys_i);
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] off, output logic [31:0] d);
        u_dsp.xfer(1'b0, {24'h00_0000, off}, 32'h0000_0000, d);
    endtask : rd

    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask : settle

    task automatic t_reset;
        logic [31:0] d;
        `CHK(ladder_rdy, 1'b0)
        `CHK({hready, hresp}, 2'b10)
        `CHK(term, 1'b1)
        `CHK({spindle, rest_pwr, rest_clk, conv, ladder}, 5'h1f)
        `CHK({seq, acq, term, dsp_run, osc_run}, 5'h1f)
        `CHK({centre, bottom, level}, 3'b110)
        `CHK({bg, gain}, 6'b100_100)
        rd(`OFF_POWER_CONTROL, d);
        `CHK(d, 32'h0000_ffff)
        rd(`OFF_REFERENCE_TRIM, d);
        `CHK(d, 32'h0000_01a4)
        settle(20);
        `CHK(ladder_rdy, 1'b1)
    endtask : t_reset

    task automatic t_trim;
        logic [31:0] d;
        wr(`OFF_REFERENCE_TRIM, 16'hffff);
        rd(`OFF_REFERENCE_TRIM, d);
        `CHK(d, 32'h0000_01ff)
        `CHK({centre, bottom, level, bg, gain}, 9'h1ff)
        wr(`OFF_REFERENCE_TRIM, 16'h0000);
        `CHK({centre, bottom, level, bg, gain}, 9'h000)
        wr(`OFF_REFERENCE_TRIM, 16'hfe98);
        `CHK({centre, bottom, level}, 3'b010)
        `CHK({bg, gain}, 6'b011_000)
        rd(8'h0c, d);
        `CHK(d, 32'h0000_0000)
    endtask : t_trim

    task automatic t_main_power;
        logic [31:0] d;
        wr(`OFF_POWER_CONTROL, 16'h1ff9);
        `CHK({spindle, rest_pwr, rest_clk}, 3'b000)
        rd(`OFF_POWER_CONTROL, d);
        `CHK(d, 32'h0000_fff9)
        wr(`OFF_POWER_CONTROL, 16'h1fff);
        `CHK({spindle, rest_pwr, rest_clk}, 3'b111)
    endtask : t_main_power

    task automatic t_park;
        wr(`OFF_POWER_CONTROL, 16'h1fde);
        `CHK({conv, seq, acq, ladder, spindle}, 5'b00001)
        wr(`OFF_POWER_CONTROL, 16'h1fff);
        `CHK({conv, seq, acq, ladder}, 4'hf)
        wr(`OFF_POWER_CONTROL, 16'h1ffe);
        `CHK({conv, seq, ladder}, 3'b001)
        wr(`OFF_POWER_CONTROL, 16'h1fff);
        wr(`OFF_POWER_CONTROL, 16'h1fde);
        // Pins pass a two-flop synchroniser before the wake takes hold
        u_dsp.pulse(0, 2);
        settle(6);
        `CHK({conv, seq, acq}, 3'b111)
        `CHK(seq, 1'b1)
        wr(`OFF_POWER_CONTROL, 16'h1fff);
        wr(`OFF_POWER_CONTROL, 16'h1fde);
        u_dsp.pulse(1, 2);
        settle(6);
        `CHK(ladder, 1'b1)
        wr(`OFF_POWER_CONTROL, 16'h1fff);
    endtask : t_park

    task automatic t_terminal;
        wr(`OFF_POWER_CONTROL, 16'h1eff);
        u_dsp.pulse(7, 1);
        settle(3);
        `CHK(term, 1'b0)
        u_dsp.pulse(6, 1);
        settle(2);
        `CHK(term, 1'b1)
        u_dsp.pulse(7, 1);
        settle(3);
        `CHK(term, 1'b0)
        u_dsp.pulse(2, 1);
        settle(6);
        `CHK(term, 1'b1)
        wr(`OFF_POWER_CONTROL, 16'h1fff);
    endtask : t_terminal

    task automatic t_core;
        logic [31:0] d;
        // Oscillator power-down bit still set: a stop must not halt it
        u_dsp.pulse(3, 1);
        settle(3);
        `CHK({dsp_run, osc_run}, 2'b01)
        wr(`OFF_POWER_CONTROL, 16'h1dff);
        u_dsp.pulse(3, 1);
        settle(3);
        `CHK({dsp_run, osc_run}, 2'b00)
        u_dsp.pulse(5, 1);
        settle(3);
        `CHK({dsp_run, osc_run}, 2'b01)
        u_dsp.pulse(4, 1);
        settle(11);
        `CHK(dsp_run, 1'b1)
        u_dsp.pulse(3, 1);
        settle(3);
        `CHK(dsp_run, 1'b0)
        u_dsp.pulse(0, 2);
        settle(14);
        `CHK(dsp_run, 1'b1)
        // Core running, oscillator halted, ladder ready, terminal active
        rd(`OFF_POWER_STATUS, d);
        `CHK(d, 32'h0000_0031)
        wr(`OFF_POWER_CONTROL, 16'h1fff);
    endtask : t_core

    initial
    begin
        #100000;
        failures++;
        final_report();
    end

    initial
    begin
        rst_n_i = 1'b0;
        repeat (6) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        settle(1);
        t_reset();
        t_trim();
        t_main_power();
        t_park();
        t_terminal();
        t_core();
        final_report();
    end
endmodule : power_gating_and_ref_trim_test
`default_nettype wire
